// *** rtx_pkg.sv ***
// constants for the real-time clock register block
package rtx_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W     = 5;
    localparam logic [4:0]  A_SEC      = 5'h00;
    localparam logic [4:0]  A_MIN      = 5'h01;
    localparam logic [4:0]  A_HOUR     = 5'h02;
    localparam logic [4:0]  A_SCRATCH  = 5'h07;
    localparam logic [4:0]  A_TMR_LO   = 5'h0b;
    localparam logic [4:0]  A_TMR_HI   = 5'h0c;
    localparam logic [4:0]  A_EXT      = 5'h0d;
    localparam logic [4:0]  A_FLAG     = 5'h0e;
    localparam logic [4:0]  A_IRQ_STAT = 5'h10;
    localparam logic [4:0]  A_IRQ_MASK = 5'h11;

    // ------------------------------------------------------------------
    // implemented-bit masks, counter limits, field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] SEC_MASK    = 8'h7f;
    localparam logic [7:0] MIN_MASK    = 8'h7f;
    localparam logic [7:0] HOUR_MASK   = 8'h3f;
    localparam logic [7:0] TMR_HI_MASK = 8'h0f;
    localparam logic [7:0] SEC_MAX     = 8'h59;
    localparam logic [7:0] MIN_MAX     = 8'h59;
    localparam logic [7:0] HOUR_MAX    = 8'h23;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;

    localparam int unsigned EXT_TEST      = 7;
    localparam int unsigned EXT_ALARM_SEL = 6;
    localparam int unsigned EXT_UPDATE_PERIOD_SELECT      = 5;
    localparam int unsigned EXT_RUN       = 4;
    localparam int unsigned EXT_FSEL_HI   = 3;
    localparam int unsigned EXT_FSEL_LO   = 2;
    localparam int unsigned EXT_TSEL_HI   = 1;
    localparam int unsigned EXT_TSEL_LO   = 0;
    localparam logic [7:0]  EXT_RESET     = 8'h00;
    localparam int unsigned FLAG_HALT     = 0;

    localparam int unsigned IRQ_W      = 3;
    localparam int unsigned IRQ_UPDATE = 0;
    localparam int unsigned IRQ_TIMER  = 1;
    localparam int unsigned IRQ_HALT   = 2;

    localparam logic [1:0] FSEL_32K_A = 2'h0;
    localparam logic [1:0] FSEL_1K    = 2'h1;
    localparam logic [1:0] FSEL_1HZ   = 2'h2;
    localparam logic [1:0] TSEL_4096  = 2'h0;
    localparam logic [1:0] TSEL_64    = 2'h1;
    localparam logic [1:0] TSEL_SEC   = 2'h2;

    // ------------------------------------------------------------------
    // time base: divider runs at twice 32768 Hz so bit 0 is a 32768 Hz square
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ   = 20_000_000;
    localparam int unsigned BASE_HZ  = 65_536;
    localparam int unsigned ACC_W    = 25;
    localparam int unsigned DIV_W    = 16;
    localparam int unsigned TAP_1K   = 5;
    localparam int unsigned TAP_1HZ  = 15;
    localparam int unsigned T4096_LO = 4;
    localparam int unsigned T64_LO   = 10;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned RTN_SEC_NS    = 500_000_000;
    localparam int unsigned RTN_MIN_NS    = 7_813_000;
    localparam int unsigned BUS_TMO_NS    = 950_000_000;
    localparam int unsigned RTN_SEC_CYC   = RTN_SEC_NS / CLK_PERIOD_NS;
    localparam int unsigned RTN_MIN_CYC   = RTN_MIN_NS / CLK_PERIOD_NS;
    localparam int unsigned BUS_TMO_CYC   = BUS_TMO_NS / CLK_PERIOD_NS;
    localparam int unsigned RTN_W         = 24;
    localparam int unsigned TMO_W         = 25;
    localparam int unsigned TMR_W         = 12;

    typedef enum logic [1:0] {
        TMR_IDLE = 2'b01,
        TMR_RUN  = 2'b10
    } rtx_tmr_state_t;

endpackage

// *** rtx_timebase.sv ***
// fractional divider making the 65536 Hz base tick and the ripple divider
`timescale 1ns/1ns
`default_nettype none
module rtx_timebase (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    // time base
    output logic                            base_tick,
    output logic [rtx_pkg::DIV_W-1:0]       div_q
);

    // ------------------------------------------------------------------
    // phase accumulator: average rate exact, jitter of one core clock
    // ------------------------------------------------------------------
    logic [rtx_pkg::ACC_W-1:0] acc_q;
    logic [rtx_pkg::ACC_W-1:0] acc_sum;
    logic                      acc_ovf;

    assign acc_sum   = acc_q + rtx_pkg::ACC_W'(rtx_pkg::BASE_HZ);
    assign acc_ovf   = acc_sum >= rtx_pkg::ACC_W'(rtx_pkg::CLK_HZ);
    assign base_tick = acc_ovf;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= '0;
            div_q <= '0;
        end else begin
            acc_q <= acc_ovf ? acc_sum - rtx_pkg::ACC_W'(rtx_pkg::CLK_HZ) : acc_sum;
            if (acc_ovf) begin
                div_q <= div_q + 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// *** rtx_bcd_cnt.sv ***
// two-digit bcd counter with host load and wrap at a given limit
`timescale 1ns/1ns
`default_nettype none
module rtx_bcd_cnt #(
    parameter logic [7:0] MAX = 8'h59
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // control
    input  wire logic       inc,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    // state
    output logic [7:0]      value_q,
    output logic            wrap
);

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction

    logic       at_max;
    logic [7:0] value_d;

    assign at_max  = value_q == MAX;
    assign wrap    = inc && at_max;
    // a host load wins over a tick in the same cycle
    assign value_d = load ? load_val : (inc ? (at_max ? 8'h00 : bcd_inc(value_q)) : value_q);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            value_q <= 8'h00;
        end else begin
            value_q <= value_d;
        end
    end

endmodule
`default_nettype wire

// *** rtx_top.sv ***
// register block of the real-time clock: time counters, extension and flag logic
`timescale 1ns/1ns
`default_nettype none
module rtx_top #(
    parameter int unsigned RTN_SEC_CYC = rtx_pkg::RTN_SEC_CYC,
    parameter int unsigned RTN_MIN_CYC = rtx_pkg::RTN_MIN_CYC,
    parameter int unsigned BUS_TMO_CYC = rtx_pkg::BUS_TMO_CYC
) (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       arst_n,
    // register port
    input  wire logic [rtx_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]                 reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic [7:0]                      reg_rdata,
    // serial front end events
    input  wire logic                       bus_stop,
    input  wire logic                       bus_rstart,
    input  wire logic                       bus_busy,
    // compensation monitor, asynchronous
    input  wire logic                       comp_halt_in,
    // outputs
    output logic                            clock_output_pin,
    output logic                            update_out,
    output logic                            alarm_target_select,
    output logic                            irq
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire wr_sec   = reg_wr && reg_addr == rtx_pkg::A_SEC;
    wire wr_min   = reg_wr && reg_addr == rtx_pkg::A_MIN;
    wire wr_hour  = reg_wr && reg_addr == rtx_pkg::A_HOUR;
    wire wr_scr   = reg_wr && reg_addr == rtx_pkg::A_SCRATCH;
    wire wr_tlo   = reg_wr && reg_addr == rtx_pkg::A_TMR_LO;
    wire wr_thi   = reg_wr && reg_addr == rtx_pkg::A_TMR_HI;
    wire wr_ext   = reg_wr && reg_addr == rtx_pkg::A_EXT;
    wire wr_flag  = reg_wr && reg_addr == rtx_pkg::A_FLAG;
    wire wr_stat  = reg_wr && reg_addr == rtx_pkg::A_IRQ_STAT;
    wire wr_mask  = reg_wr && reg_addr == rtx_pkg::A_IRQ_MASK;

    // ------------------------------------------------------------------
    // time base
    // ------------------------------------------------------------------
    logic                      base_tick;
    logic [rtx_pkg::DIV_W-1:0] div_q;

    rtx_timebase u_tb (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .base_tick (base_tick),
        .div_q     (div_q)
    );

    wire tick_1hz  = base_tick && (&div_q);
    wire tick_4096 = base_tick && (&div_q[rtx_pkg::T4096_LO-1:0]);
    wire tick_64   = base_tick && (&div_q[rtx_pkg::T64_LO-1:0]);

    // ------------------------------------------------------------------
    // time counters
    // ------------------------------------------------------------------
    logic [7:0] sec_q;
    logic [7:0] min_q;
    logic [7:0] hour_q;
    logic       sec_wrap;
    logic       min_wrap;

    // carries are combinational so all three settle on the same tick
    wire min_inc  = sec_wrap;
    wire hour_inc = min_wrap;

    rtx_bcd_cnt #(.MAX(rtx_pkg::SEC_MAX)) u_sec (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .inc      (tick_1hz),
        .load     (wr_sec),
        .load_val (reg_wdata & rtx_pkg::SEC_MASK),
        .value_q  (sec_q),
        .wrap     (sec_wrap)
    );

    rtx_bcd_cnt #(.MAX(rtx_pkg::MIN_MAX)) u_min (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .inc      (min_inc),
        .load     (wr_min),
        .load_val (reg_wdata & rtx_pkg::MIN_MASK),
        .value_q  (min_q),
        .wrap     (min_wrap)
    );

    rtx_bcd_cnt #(.MAX(rtx_pkg::HOUR_MAX)) u_hour (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .inc      (hour_inc),
        .load     (wr_hour),
        .load_val (reg_wdata & rtx_pkg::HOUR_MASK),
        .value_q  (hour_q),
        .wrap     ()
    );

    // ------------------------------------------------------------------
    // plain storage registers
    // ------------------------------------------------------------------
    logic [7:0] scr_q;
    logic [7:0] tlo_q;
    logic [7:0] thi_q;
    logic [rtx_pkg::IRQ_W-1:0] mask_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            scr_q  <= 8'h00;
            tlo_q  <= 8'h00;
            thi_q  <= 8'h00;
            mask_q <= '0;
        end else begin
            if (wr_scr)  scr_q  <= reg_wdata;
            if (wr_tlo)  tlo_q  <= reg_wdata;
            if (wr_thi)  thi_q  <= reg_wdata & rtx_pkg::TMR_HI_MASK;
            if (wr_mask) mask_q <= reg_wdata[rtx_pkg::IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // bus timeout and extension register
    // ------------------------------------------------------------------
    logic [rtx_pkg::TMO_W-1:0] tmo_q;
    logic [7:0]                ext_q;
    logic [7:0]                ext_d;

    wire tmo_fire  = bus_busy && tmo_q == rtx_pkg::TMO_W'(BUS_TMO_CYC - 1);
    wire test_clr  = bus_stop || bus_rstart || tmo_fire;
    wire run_start = wr_ext && reg_wdata[rtx_pkg::EXT_RUN] && !ext_q[rtx_pkg::EXT_RUN];

    // the safety clear beats a same-cycle write of a one
    always_comb begin
        ext_d = wr_ext ? reg_wdata : ext_q;
        if (test_clr) begin
            ext_d[rtx_pkg::EXT_TEST] = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tmo_q <= '0;
            ext_q <= rtx_pkg::EXT_RESET;
        end else begin
            tmo_q <= (bus_busy && !tmo_fire) ? tmo_q + 1'b1 : '0;
            ext_q <= ext_d;
        end
    end

    assign alarm_target_select = ext_q[rtx_pkg::EXT_ALARM_SEL];

    // ------------------------------------------------------------------
    // clock output select
    // ------------------------------------------------------------------
    logic       clk_out_q;
    wire  [1:0] fsel = {ext_q[rtx_pkg::EXT_FSEL_HI], ext_q[rtx_pkg::EXT_FSEL_LO]};
    wire        clk_out_d = (fsel == rtx_pkg::FSEL_1K)  ? div_q[rtx_pkg::TAP_1K]  :
                            (fsel == rtx_pkg::FSEL_1HZ) ? div_q[rtx_pkg::TAP_1HZ] :
                            div_q[0];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_out_q <= 1'b0;
        end else begin
            clk_out_q <= clk_out_d;
        end
    end

    assign clock_output_pin = clk_out_q;

    // ------------------------------------------------------------------
    // update event and auto return
    // ------------------------------------------------------------------
    logic [rtx_pkg::RTN_W-1:0] rtn_q;
    logic                      upd_out_q;

    wire use_min   = ext_q[rtx_pkg::EXT_UPDATE_PERIOD_SELECT];
    wire upd_evt   = use_min ? sec_wrap : tick_1hz;
    wire [rtx_pkg::RTN_W-1:0] rtn_len = use_min ? rtx_pkg::RTN_W'(RTN_MIN_CYC)
                                                : rtx_pkg::RTN_W'(RTN_SEC_CYC);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rtn_q     <= '0;
            upd_out_q <= 1'b0;
        end else begin
            if (upd_evt) begin
                rtn_q     <= rtn_len;
                upd_out_q <= 1'b1;
            end else if (rtn_q > rtx_pkg::RTN_W'(1)) begin
                rtn_q     <= rtn_q - 1'b1;
            end else begin
                rtn_q     <= '0;
                upd_out_q <= 1'b0;
            end
        end
    end

    assign update_out = upd_out_q;

    // ------------------------------------------------------------------
    // fixed-cycle countdown
    // ------------------------------------------------------------------
    rtx_pkg::rtx_tmr_state_t   tmr_st_q;
    rtx_pkg::rtx_tmr_state_t   tmr_st_d;
    logic [rtx_pkg::TMR_W-1:0] tcnt_q;
    logic [rtx_pkg::TMR_W-1:0] tcnt_d;

    wire [rtx_pkg::TMR_W-1:0] preset = {thi_q[3:0], tlo_q};
    wire [1:0] tsel     = {ext_q[rtx_pkg::EXT_TSEL_HI], ext_q[rtx_pkg::EXT_TSEL_LO]};
    wire       src_tick = (tsel == rtx_pkg::TSEL_4096) ? tick_4096 :
                          (tsel == rtx_pkg::TSEL_64)   ? tick_64   :
                          (tsel == rtx_pkg::TSEL_SEC)  ? tick_1hz  : sec_wrap;
    // no event in the cycle in which a cleared run bit is still moving the state to idle
    wire       tmr_evt  = tmr_st_q == rtx_pkg::TMR_RUN && ext_q[rtx_pkg::EXT_RUN] && src_tick
                          && tcnt_q == rtx_pkg::TMR_W'(1);

    always_comb begin
        tmr_st_d = tmr_st_q;
        tcnt_d   = tcnt_q;
        case (tmr_st_q)
            rtx_pkg::TMR_IDLE: begin
                if (run_start) begin
                    tmr_st_d = rtx_pkg::TMR_RUN;
                    tcnt_d   = preset;
                end
            end
            rtx_pkg::TMR_RUN: begin
                if (!ext_q[rtx_pkg::EXT_RUN]) begin
                    tmr_st_d = rtx_pkg::TMR_IDLE;
                end else if (src_tick) begin
                    tcnt_d = (tcnt_q <= rtx_pkg::TMR_W'(1)) ? preset : tcnt_q - 1'b1;
                end
            end
            default: begin
                tmr_st_d = rtx_pkg::TMR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tmr_st_q <= rtx_pkg::TMR_IDLE;
            tcnt_q   <= '0;
        end else begin
            tmr_st_q <= tmr_st_d;
            tcnt_q   <= tcnt_d;
        end
    end

    // ------------------------------------------------------------------
    // compensation halt flag
    // ------------------------------------------------------------------
    logic halt_s1_q;
    logic halt_s2_q;
    logic halt_s3_q;
    logic flag_q;

    wire halt_rise = halt_s2_q && !halt_s3_q;
    wire flag_wclr = wr_flag && !reg_wdata[rtx_pkg::FLAG_HALT];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            halt_s1_q <= 1'b0;
            halt_s2_q <= 1'b0;
            halt_s3_q <= 1'b0;
            flag_q    <= 1'b1;
        end else begin
            halt_s1_q <= comp_halt_in;
            halt_s2_q <= halt_s1_q;
            halt_s3_q <= halt_s2_q;
            // a halt still present keeps the flag set over a clear
            flag_q    <= halt_s2_q || (flag_q && !flag_wclr);
        end
    end

    // ------------------------------------------------------------------
    // interrupt status
    // ------------------------------------------------------------------
    logic [rtx_pkg::IRQ_W-1:0] stat_q;
    wire  [rtx_pkg::IRQ_W-1:0] stat_set;
    wire  [rtx_pkg::IRQ_W-1:0] stat_clr;

    assign stat_set = {halt_rise, tmr_evt, upd_evt};
    assign stat_clr = wr_stat ? reg_wdata[rtx_pkg::IRQ_W-1:0] : '0;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    assign irq = |(stat_q & mask_q);

    // ------------------------------------------------------------------
    // read mux, data valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;

    always_comb begin
        case (reg_addr)
            rtx_pkg::A_SEC:      rd_mux = sec_q & rtx_pkg::SEC_MASK;
            rtx_pkg::A_MIN:      rd_mux = min_q & rtx_pkg::MIN_MASK;
            rtx_pkg::A_HOUR:     rd_mux = hour_q & rtx_pkg::HOUR_MASK;
            rtx_pkg::A_SCRATCH:  rd_mux = scr_q;
            rtx_pkg::A_TMR_LO:   rd_mux = tlo_q;
            rtx_pkg::A_TMR_HI:   rd_mux = thi_q;
            rtx_pkg::A_EXT:      rd_mux = ext_q;
            rtx_pkg::A_FLAG:     rd_mux = {7'h00, flag_q};
            rtx_pkg::A_IRQ_STAT: rd_mux = {5'h00, stat_q};
            rtx_pkg::A_IRQ_MASK: rd_mux = {5'h00, mask_q};
            default:             rd_mux = rtx_pkg::ZERO_BYTE;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_mux : rtx_pkg::ZERO_BYTE;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    halt_sets_flag_a: assert property (
        halt_s2_q |=> flag_q) else $error("halt did not set the flag");
    flag_clear_cause_a: assert property (
        $fell(flag_q) |-> $past(flag_wclr)) else $error("flag fell without a zero write");
    one_write_noop_a: assert property (
        wr_flag && reg_wdata[0] && !flag_q && !halt_s2_q |=> !flag_q) else $error("writing one set the flag");
    sec_top_zero_a: assert property (
        reg_rd && reg_addr == rtx_pkg::A_SEC ##1 1'b1 |-> !reg_rdata[7]) else $error("protected bit read one");
    test_autoclr_a: assert property (
        bus_stop || bus_rstart |=> !ext_q[rtx_pkg::EXT_TEST]) else $error("test bit not cleared");
    scratch_back_a: assert property (
        wr_scr ##1 !wr_scr ##1 (reg_rd && reg_addr == rtx_pkg::A_SCRATCH && !reg_wr)
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("scratch readback wrong");
    sec_wrap_a: assert property (
        tick_1hz && sec_q == rtx_pkg::SEC_MAX && !wr_sec |=> sec_q == 8'h00) else $error("seconds did not wrap");
    hour_wrap_a: assert property (
        sec_wrap && min_q == rtx_pkg::MIN_MAX && hour_q == rtx_pkg::HOUR_MAX && !wr_min && !wr_hour
        |=> hour_q == 8'h00 && min_q == 8'h00) else $error("hours did not wrap");
    timer_load_a: assert property (
        run_start && tmr_st_q == rtx_pkg::TMR_IDLE |=> tcnt_q == $past(preset) && tmr_st_q == rtx_pkg::TMR_RUN)
        else $error("timer not loaded from preset");
    clkout_rate_a: assert property (
        fsel == rtx_pkg::FSEL_1K && $stable(fsel) |=> clock_output_pin == $past(div_q[rtx_pkg::TAP_1K]))
        else $error("clock output rate wrong");

    sec_wrap_c:  cover property (sec_wrap);
    tmr_evt_c:   cover property (tmr_evt);
    test_clr_c:  cover property (ext_q[rtx_pkg::EXT_TEST] ##1 !ext_q[rtx_pkg::EXT_TEST]);
    flag_clr_c:  cover property ($fell(flag_q));

endmodule
`default_nettype wire

// *** rtx_host.sv ***
// host model driving the register port
`timescale 1ns/1ns
`default_nettype none
module rtx_host (
    // clock
    input  wire logic                       core_clk,
    // register port
    output logic [rtx_pkg::ADDR_W-1:0]      reg_addr,
    output logic [7:0]                      reg_wdata,
    output logic                            reg_wr,
    output logic                            reg_rd,
    input  wire logic [7:0]                 reg_rdata
);
    initial begin
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
    end
    // valid times and a low test bit unless a scenario means a fault
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// *** test_rtx_top.sv ***
// self-checking testbench for the rtx register block
`timescale 1ns/1ns
`default_nettype none
module test_rtx_top;
    logic       core_clk, arst_n, bus_stop, bus_rstart, bus_busy, comp_halt_in;
    logic       reg_wr, reg_rd, cko, upd, alarm, irq;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    int         err_total, checks;
    rtx_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    rtx_top #(.RTN_SEC_CYC(20), .RTN_MIN_CYC(5), .BUS_TMO_CYC(16)) dut (.core_clk(core_clk),
        .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_stop(bus_stop), .bus_rstart(bus_rstart),
        .bus_busy(bus_busy), .comp_halt_in(comp_halt_in), .clock_output_pin(cko),
        .update_out(upd), .alarm_target_select(alarm), .irq(irq));
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(input string n, input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        check(n, d, e);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rc("flag", rtx_pkg::A_FLAG, 8'h01);
        rc("ext", rtx_pkg::A_EXT, 8'h00);
        rc("unmapped", 5'h1f, 8'h00);
        check("update", {7'h00, upd}, 8'h00);
    endtask
    task automatic t_regs();
        logic [4:0] a [4] = '{rtx_pkg::A_SEC, rtx_pkg::A_MIN, rtx_pkg::A_HOUR, rtx_pkg::A_SCRATCH};
        logic [7:0] m [4] = '{8'h7f, 8'h7f, 8'h3f, 8'hff};
        logic [7:0] b [4] = '{8'h59, 8'h59, 8'h23, 8'ha5};
        for (int i = 0; i < 4; i++) begin
            host.wr(a[i], 8'hff);
            rc("masked", a[i], m[i]);
            host.wr(a[i], b[i]);
            rc("bcd", a[i], b[i]);
            host.wr(a[i], 8'h00);
            rc("zero", a[i], 8'h00);
        end
    endtask
    task automatic t_ext();
        host.wr(rtx_pkg::A_EXT, 8'h7f);
        rc("ext", rtx_pkg::A_EXT, 8'h7f);
        check("alarm", {7'h00, alarm}, 8'h01);
        host.wr(rtx_pkg::A_EXT, 8'h00);
        rc("ext", rtx_pkg::A_EXT, 8'h00);
        check("alarm", {7'h00, alarm}, 8'h00);
    endtask
    // stop, repeated start, then a busy bus outlasting the timeout
    task automatic t_test();
        for (int k = 0; k < 3; k++) begin
            host.wr(rtx_pkg::A_EXT, 8'h80);
            rc("test set", rtx_pkg::A_EXT, 8'h80);
            @(posedge core_clk);
            bus_stop <= (k == 0);
            bus_rstart <= (k == 1);
            bus_busy <= (k == 2);
            repeat (k == 2 ? 18 : 1) @(posedge core_clk);
            {bus_stop, bus_rstart, bus_busy} <= 3'h0;
            rc("test clr", rtx_pkg::A_EXT, 8'h00);
        end
    endtask
    task automatic t_halt();
        int n;
        host.wr(rtx_pkg::A_FLAG, 8'h00);
        rc("flag clr", rtx_pkg::A_FLAG, 8'h00);
        host.wr(rtx_pkg::A_FLAG, 8'h01);
        rc("flag w1", rtx_pkg::A_FLAG, 8'h00);
        host.wr(rtx_pkg::A_IRQ_MASK, 8'h04);
        comp_halt_in <= 1'h1;
        for (n = 0; n < 10 && irq !== 1'h1; n++) @(posedge core_clk);
        if (n == 10) begin
            err_total++;
            final_report();
        end
        comp_halt_in <= 1'h0;
        rc("flag set", rtx_pkg::A_FLAG, 8'h01);
        rc("status", rtx_pkg::A_IRQ_STAT, 8'h04);
        host.wr(rtx_pkg::A_IRQ_STAT, 8'h04);
        @(posedge core_clk);
        check("irq clr", {7'h00, irq}, 8'h00);
        host.wr(rtx_pkg::A_IRQ_MASK, 8'h00);
        host.wr(rtx_pkg::A_FLAG, 8'h00);
        comp_halt_in <= 1'h1;
        repeat (6) @(posedge core_clk);
        comp_halt_in <= 1'h0;
        check("irq mask", {7'h00, irq}, 8'h00);
        rc("flag set", rtx_pkg::A_FLAG, 8'h01);
    endtask
    // preset of one on the 4096 Hz source, then stopped for longer than a tick
    task automatic t_tmr();
        int n;
        host.wr(rtx_pkg::A_TMR_HI, 8'hf0);
        rc("preset hi", rtx_pkg::A_TMR_HI, 8'h00);
        host.wr(rtx_pkg::A_TMR_LO, 8'h01);
        host.wr(rtx_pkg::A_IRQ_STAT, 8'h07);
        host.wr(rtx_pkg::A_IRQ_MASK, 8'h02);
        host.wr(rtx_pkg::A_EXT, 8'h10);
        for (n = 0; n < 6000 && irq !== 1'h1; n++) @(posedge core_clk);
        check("timer event", {7'h00, irq}, 8'h01);
        if (n == 6000) final_report();
        host.wr(rtx_pkg::A_EXT, 8'h00);
        host.wr(rtx_pkg::A_IRQ_STAT, 8'h02);
        repeat (6000) @(posedge core_clk);
        check("timer stop", {7'h00, irq}, 8'h00);
    endtask
    // rising edges of the output over a little more than 1/1024 s
    task automatic t_rate();
        logic [7:0] lo [4] = '{8'h1f, 8'h01, 8'h00, 8'h1f};
        logic [7:0] hi [4] = '{8'h21, 8'h02, 8'h00, 8'h21};
        logic [7:0] n;
        logic       p;
        for (int s = 0; s < 4; s++) begin
            host.wr(rtx_pkg::A_EXT, 8'(s << 2));
            repeat (2) @(posedge core_clk);
            n = 8'h00;
            p = cko;
            repeat (19600) begin
                @(posedge core_clk);
                n += {7'h00, cko & ~p};
                p = cko;
            end
            check("rate", {7'h00, n >= lo[s] && n <= hi[s]}, 8'h01);
        end
    endtask
    initial begin
        err_total = 0;
        checks = 0;
        {arst_n, bus_stop, bus_rstart, bus_busy, comp_halt_in} = 5'h00;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'h1;
        t_reset();
        t_regs();
        t_ext();
        t_test();
        t_halt();
        t_tmr();
        t_rate();
        final_report();
    end
endmodule
`default_nettype wire
